// ### verilog/xfer_pkg.sv
// shared constants and types for the data-transfer execution unit
// assumes one core clock and a single shared memory port
package xfer_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NREGS  = 16;
    localparam logic [31:0] REG_RESET   = 32'h0000_0000;
    localparam logic [31:0] PC_RESET    = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam int unsigned COND_BIT    = 0;
    localparam int unsigned PRIV_BIT    = 30;

    // operand sizes: byte, word, longword
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } size_type;

    // execution operations
    typedef enum logic [3:0] {
        OP_NONE     = 4'h0,
        OP_IMM      = 4'h1,
        OP_REG      = 4'h2,
        OP_PC_LOAD  = 4'h3,
        OP_LOAD     = 4'h4,
        OP_STORE    = 4'h5,
        OP_PRE_DEC  = 4'h6,
        OP_POST_INC = 4'h7
    } op_type;

    // field positions
    localparam int unsigned N_LSB = 8;
    localparam int unsigned M_LSB = 4;

    // opcode patterns
    localparam logic [3:0] GRP_IDX   = 4'h0;
    localparam logic [3:0] GRP_DSTL  = 4'h1;
    localparam logic [3:0] GRP_STOR  = 4'h2;
    localparam logic [3:0] GRP_DLDL  = 4'h5;
    localparam logic [3:0] GRP_LOAD  = 4'h6;
    localparam logic [3:0] GRP_DISP  = 4'h8;
    localparam logic [3:0] GRP_PCW   = 4'h9;
    localparam logic [3:0] GRP_PCL   = 4'hd;
    localparam logic [3:0] GRP_IMM   = 4'he;
    localparam logic [3:0] SUB_IDX_B = 4'h4;
    localparam logic [3:0] SUB_MOVE  = 4'h3;
    localparam logic [3:0] SUB_DSB   = 4'h0;
    localparam logic [3:0] SUB_DSW   = 4'h1;
    localparam logic [3:0] SUB_DLB   = 4'h4;
    localparam logic [3:0] SUB_DLW   = 4'h5;

    // scale a displacement by operand size
    function automatic logic [31:0] scale_disp(input logic [31:0] d,
                                                input size_type sz);
        unique case (sz)
            SZ_BYTE: scale_disp = d;
            SZ_WORD: scale_disp = {d[30:0], 1'b0};
            default: scale_disp = {d[29:0], 2'b00};
        endcase
    endfunction : scale_disp

    // operand size in bytes
    function automatic logic [31:0] size_bytes(input size_type sz);
        unique case (sz)
            SZ_BYTE: size_bytes = 32'h0000_0001;
            SZ_WORD: size_bytes = 32'h0000_0002;
            default: size_bytes = 32'h0000_0004;
        endcase
    endfunction : size_bytes

    // sign extend a loaded operand
    function automatic logic [31:0] sign_ext(input logic [31:0] d,
                                              input size_type sz);
        unique case (sz)
            SZ_BYTE: sign_ext = {{24{d[7]}}, d[7:0]};
            SZ_WORD: sign_ext = {{16{d[15]}}, d[15:0]};
            default: sign_ext = d;
        endcase
    endfunction : sign_ext
endpackage : xfer_pkg

// ### verilog/regfile_if.sv
// general register file access bundle
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface regfile_if;
    logic [3:0]  rd_a_addr;
    logic [3:0]  rd_b_addr;
    logic [31:0] rd_a_data;
    logic [31:0] rd_b_data;
    logic [31:0] rd_z_data;
    logic        wr_a_en;
    logic [3:0]  wr_a_addr;
    logic [31:0] wr_a_data;
    logic        wr_b_en;
    logic [3:0]  wr_b_addr;
    logic [31:0] wr_b_data;
    modport core (output rd_a_addr, rd_b_addr, wr_a_en, wr_a_addr,
                  wr_a_data, wr_b_en, wr_b_addr, wr_b_data,
                  input rd_a_data, rd_b_data, rd_z_data);
    modport store (input rd_a_addr, rd_b_addr, wr_a_en, wr_a_addr,
                   wr_a_data, wr_b_en, wr_b_addr, wr_b_data,
                   output rd_a_data, rd_b_data, rd_z_data);
endinterface : regfile_if

// ### verilog/gp_regfile.sv
// sixteen general registers, two write ports, combinational reads
// assumes write port a wins when both ports hit one register
`timescale 1ns/100ps
module gp_regfile (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    regfile_if.store  rf
);
    logic [31:0] regs_ff [xfer_pkg::NREGS];

    always_ff @(posedge clk_in) begin
        for (int i = 0; i < int'(xfer_pkg::NREGS); i++) begin
            if (sys_rst_in) begin
                regs_ff[i] <= xfer_pkg::REG_RESET;
            end else if (rf.wr_a_en && rf.wr_a_addr == 4'(i)) begin
                regs_ff[i] <= rf.wr_a_data;
            end else if (rf.wr_b_en && rf.wr_b_addr == 4'(i)) begin
                regs_ff[i] <= rf.wr_b_data;
            end
        end
    end

    assign rf.rd_a_data = regs_ff[rf.rd_a_addr];
    assign rf.rd_b_data = regs_ff[rf.rd_b_addr];
    assign rf.rd_z_data = regs_ff[0];
endmodule : gp_regfile

// ### verilog/xfer_decode.sv
// instruction decode for the data-transfer group
// assumes a 16-bit instruction word from the fetch stage
`timescale 1ns/100ps
module xfer_decode (
    input  wire logic [15:0]        instr_in,
    output xfer_pkg::op_type        op_out,
    output xfer_pkg::size_type      size_out,
    output logic [3:0]              src_reg_out,
    output logic [3:0]              dst_reg_out,
    output logic [3:0]              base_reg_out,
    output logic [31:0]             disp_out,
    output logic                    index_out
);
    logic [3:0] grp;
    logic [3:0] nfld;
    logic [3:0] mfld;
    logic [3:0] low;

    assign grp  = instr_in[15:12];
    assign nfld = instr_in[xfer_pkg::N_LSB +: 4];
    assign mfld = instr_in[xfer_pkg::M_LSB +: 4];
    assign low  = instr_in[3:0];

    always_comb begin
        op_out       = xfer_pkg::OP_NONE;
        size_out     = xfer_pkg::SZ_LONG;
        src_reg_out  = mfld;
        dst_reg_out  = nfld;
        base_reg_out = nfld;
        disp_out     = 32'h0000_0000;
        index_out    = 1'b0;
        unique case (grp)
            xfer_pkg::GRP_IMM: begin
                op_out   = xfer_pkg::OP_IMM;
                disp_out = {{24{instr_in[7]}}, instr_in[7:0]};
            end
            xfer_pkg::GRP_PCW, xfer_pkg::GRP_PCL: begin
                op_out   = xfer_pkg::OP_PC_LOAD;
                size_out = (grp == xfer_pkg::GRP_PCW) ? xfer_pkg::SZ_WORD
                                                      : xfer_pkg::SZ_LONG;
                disp_out = {24'h00_0000, instr_in[7:0]};
            end
            xfer_pkg::GRP_IDX: begin
                if (low[3:2] == 2'b01 && low[1:0] != 2'b11) begin
                    op_out    = xfer_pkg::OP_STORE;
                    size_out  = xfer_pkg::size_type'(low[1:0]);
                    index_out = 1'b1;
                end
            end
            xfer_pkg::GRP_STOR: begin
                if (low[1:0] != 2'b11 && !low[3]) begin
                    op_out   = low[2] ? xfer_pkg::OP_PRE_DEC
                                      : xfer_pkg::OP_STORE;
                    size_out = xfer_pkg::size_type'(low[1:0]);
                end
            end
            xfer_pkg::GRP_LOAD: begin
                if (low == xfer_pkg::SUB_MOVE) begin
                    op_out = xfer_pkg::OP_REG;
                end else if (low[1:0] != 2'b11 && !low[3]) begin
                    op_out   = low[2] ? xfer_pkg::OP_POST_INC
                                      : xfer_pkg::OP_LOAD;
                    size_out = xfer_pkg::size_type'(low[1:0]);
                    base_reg_out = mfld;
                end
            end
            xfer_pkg::GRP_DSTL: begin
                op_out   = xfer_pkg::OP_STORE;
                disp_out = {28'h000_0000, low};
            end
            xfer_pkg::GRP_DLDL: begin
                op_out       = xfer_pkg::OP_LOAD;
                base_reg_out = mfld;
                disp_out     = {28'h000_0000, low};
            end
            xfer_pkg::GRP_DISP: begin
                disp_out = {28'h000_0000, low};
                unique case (nfld)
                    xfer_pkg::SUB_DSB, xfer_pkg::SUB_DSW: begin
                        op_out       = xfer_pkg::OP_STORE;
                        size_out     = xfer_pkg::size_type'(nfld[1:0]);
                        src_reg_out  = 4'h0;
                        base_reg_out = mfld;
                    end
                    xfer_pkg::SUB_DLB, xfer_pkg::SUB_DLW: begin
                        op_out       = xfer_pkg::OP_LOAD;
                        size_out     = xfer_pkg::size_type'(nfld[1:0]);
                        dst_reg_out  = 4'h0;
                        base_reg_out = mfld;
                    end
                    default: op_out = xfer_pkg::OP_NONE;
                endcase
            end
            default: op_out = xfer_pkg::OP_NONE;
        endcase
    end
endmodule : xfer_decode

// ### verilog/cpu_data_transfer_decode.sv
// data-transfer execution unit: decode, address, load and store
// assumes a single memory port shared by fetch and data, ready handshake
// What this block does
// - four-bit fields select registers zero to fifteen
// - displacements scaled by operand size
// - one execution cycle without wait states, except loads, which take two
// - stall when fetch and data access collide
// - stall the next instruction after a memory load, dependent or not
// - condition flag left unchanged
// - same behaviour in user and privileged modes
// - immediate sign extended into destination
// - pc word load, displacement times two
// - pc longword load, displacement times four
// - indirect loads, byte and word sign extended
// - pre-decrement by size, then store
// - post-increment load, source advanced by size
// - byte and word displacement stores from register zero
// - longword displacement store, scaled by four
// - displacement loads; byte, word into register zero
// - indexed store at register zero plus destination
`timescale 1ns/100ps
module cpu_data_transfer_decode (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        instr_valid_in,
    input  wire logic [15:0] instr_in,
    input  wire logic [31:0] instr_pc_in,
    output logic             instr_ready_out,
    input  wire logic        fetch_req_in,
    output logic             mem_req_out,
    output logic             mem_we_out,
    output logic [31:0]      mem_addr_out,
    output logic [31:0]      mem_wdata_out,
    output logic [1:0]       mem_size_out,
    input  wire logic        mem_ready_in,
    input  wire logic [31:0] mem_rdata_in,
    input  wire logic        status_load_in,
    input  wire logic [31:0] status_data_in,
    output logic [31:0]      status_word_out,
    output logic             illegal_out
);
    // =========================================================
    // state
    // =========================================================
    typedef enum logic [1:0] {
        ST_ISSUE = 2'b00,
        ST_MEM   = 2'b01,
        ST_WB    = 2'b11
    } state_type;

    state_type             state_ff;
    logic [15:0]           ins_ff;
    logic [31:0]           pc_ff;
    logic [31:0]           status_ff;
    logic [31:0]           rdata_ff;
    logic                  illegal_ff;
    logic                  load_busy;

    // =========================================================
    // decode and register file
    // =========================================================
    xfer_pkg::op_type      op;
    xfer_pkg::size_type    sz;
    logic [3:0]            src_r;
    logic [3:0]            dst_r;
    logic [3:0]            base_r;
    logic [31:0]           disp;
    logic                  idx;

    regfile_if rf ();

    xfer_decode u_dec (
        .instr_in     (ins_ff),
        .op_out       (op),
        .size_out     (sz),
        .src_reg_out  (src_r),
        .dst_reg_out  (dst_r),
        .base_reg_out (base_r),
        .disp_out     (disp),
        .index_out    (idx)
    );

    gp_regfile u_rf (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .rf         (rf.store)
    );

    assign rf.rd_a_addr = src_r;
    assign rf.rd_b_addr = base_r;

    // =========================================================
    // address generation
    // =========================================================
    logic [31:0] base_val;
    logic [31:0] eff_addr;
    logic [31:0] step;
    logic        is_mem;
    logic        is_load;
    logic        conflict;

    assign step = xfer_pkg::size_bytes(sz);

    always_comb begin
        base_val = rf.rd_b_data;
        if (op == xfer_pkg::OP_PC_LOAD) begin
            base_val = pc_ff;
        end
        if (idx) begin
            base_val = rf.rd_b_data + rf.rd_z_data;
        end
        if (op == xfer_pkg::OP_PRE_DEC) begin
            eff_addr = rf.rd_b_data - step;
        end else begin
            eff_addr = base_val + xfer_pkg::scale_disp(disp, sz);
        end
    end

    assign is_load = (op == xfer_pkg::OP_LOAD)
                  || (op == xfer_pkg::OP_POST_INC)
                  || (op == xfer_pkg::OP_PC_LOAD);
    assign is_mem  = is_load || (op == xfer_pkg::OP_STORE)
                  || (op == xfer_pkg::OP_PRE_DEC);
    // fetch has the memory path this cycle; data waits
    assign conflict = fetch_req_in;

    // =========================================================
    // sequencing
    // =========================================================
    // a loaded value is written in ST_WB before the next instruction
    // is accepted, so a dependent reader always sees it
    assign load_busy       = (state_ff != ST_ISSUE) ||
                             (have_ff && is_mem &&
                              (is_load || conflict || !mem_ready_in));
    assign instr_ready_out = !load_busy;

    logic        have_ff;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            have_ff <= 1'b0;
            ins_ff  <= 16'h0000;
            pc_ff   <= xfer_pkg::PC_RESET;
        end else if (instr_ready_out) begin
            have_ff <= instr_valid_in;
            ins_ff  <= instr_valid_in ? instr_in : 16'h0000;
            pc_ff   <= instr_pc_in;
        end else begin
            have_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_ff <= ST_ISSUE;
        end else begin
            unique case (state_ff)
                ST_ISSUE: begin
                    if (have_ff && is_mem &&
                        (conflict || !mem_ready_in || is_load)) begin
                        state_ff <= (!conflict && mem_ready_in)
                                    ? ST_WB : ST_MEM;
                    end
                end
                ST_MEM: begin
                    if (!conflict && mem_ready_in) begin
                        state_ff <= is_load ? ST_WB : ST_ISSUE;
                    end
                end
                ST_WB: state_ff <= ST_ISSUE;
                default: state_ff <= ST_ISSUE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_ff <= 32'h0000_0000;
        end else if (mem_req_out && mem_ready_in && !mem_we_out) begin
            rdata_ff <= xfer_pkg::sign_ext(mem_rdata_in, sz);
        end
    end

    // =========================================================
    // memory port
    // =========================================================
    logic mem_phase;
    assign mem_phase = is_mem && !conflict &&
                       ((have_ff && state_ff == ST_ISSUE) ||
                        state_ff == ST_MEM);

    assign mem_req_out   = mem_phase;
    assign mem_we_out    = mem_phase && !is_load;
    assign mem_addr_out  = eff_addr;
    assign mem_wdata_out = rf.rd_a_data;
    assign mem_size_out  = sz;

    // =========================================================
    // register writeback
    // =========================================================
    logic store_done;
    logic load_done;
    assign store_done = mem_phase && mem_ready_in && !is_load;
    assign load_done  = (state_ff == ST_WB);

    always_comb begin
        rf.wr_a_en   = 1'b0;
        rf.wr_a_addr = dst_r;
        rf.wr_a_data = rdata_ff;
        rf.wr_b_en   = 1'b0;
        rf.wr_b_addr = base_r;
        rf.wr_b_data = eff_addr;
        // privilege bit is never consulted here
        if (have_ff && state_ff == ST_ISSUE) begin
            if (op == xfer_pkg::OP_IMM) begin
                rf.wr_a_en   = 1'b1;
                rf.wr_a_data = disp;
            end else if (op == xfer_pkg::OP_REG) begin
                rf.wr_a_en   = 1'b1;
                rf.wr_a_data = rf.rd_a_data;
            end
        end
        if (load_done) begin
            rf.wr_a_en = 1'b1;
        end
        if (store_done && op == xfer_pkg::OP_PRE_DEC) begin
            rf.wr_b_en = 1'b1;
        end
        if (load_done && op == xfer_pkg::OP_POST_INC) begin
            rf.wr_b_en   = 1'b1;
            rf.wr_b_data = rf.rd_b_data + step;
        end
    end

    // =========================================================
    // status word and error flag
    // =========================================================
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            status_ff <= xfer_pkg::STATUS_RESET;
        end else if (status_load_in) begin
            status_ff <= status_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            illegal_ff <= 1'b0;
        end else begin
            illegal_ff <= have_ff && state_ff == ST_ISSUE &&
                          op == xfer_pkg::OP_NONE;
        end
    end

    assign status_word_out = status_ff;
    assign illegal_out     = illegal_ff;
endmodule : cpu_data_transfer_decode

// ### tb/xfer_monitor.sv
// port checker for the data-transfer unit
// assumes a bind from the bench top file
`timescale 1ns/100ps
module xfer_monitor (
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic        instr_valid_in,
    input wire logic [15:0] instr_in,
    input wire logic [31:0] instr_pc_in,
    input wire logic        instr_ready_out,
    input wire logic        fetch_req_in,
    input wire logic        mem_req_out,
    input wire logic        mem_we_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic [1:0]  mem_size_out,
    input wire logic        mem_ready_in,
    input wire logic        status_load_in,
    input wire logic [31:0] status_data_in,
    input wire logic [31:0] status_word_out
);
    // ========================================
    // sequences
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence s_take;
        instr_valid_in && instr_ready_out;
    endsequence
    sequence s_ld_done;
        mem_req_out && !mem_we_out && mem_ready_in && !fetch_req_in;
    endsequence
    sequence s_pc(logic [3:0] grp);
        instr_valid_in && instr_ready_out && instr_in[15:12] == grp
            ##1 !fetch_req_in;
    endsequence
    // ========================================
    // assertions
    AST_ONE_CYCLE: assert property (
        s_take ##1 !fetch_req_in |-> instr_ready_out || mem_req_out)
        else $error("no progress after take");
    AST_HOLD_REQ: assert property (
        mem_req_out && !mem_ready_in && !fetch_req_in ##1 !fetch_req_in
        |-> mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out))
        else $error("memory request dropped");
    AST_LOAD_BLOCK: assert property (
        mem_req_out && !mem_we_out |-> !instr_ready_out)
        else $error("ready during load");
    AST_LOAD_WB: assert property (
        s_ld_done |=> !instr_ready_out ##1 instr_ready_out)
        else $error("load writeback timing");
    AST_STATUS_KEEP: assert property (
        !status_load_in |=> $stable(status_word_out))
        else $error("status word changed");
    AST_STATUS_LOAD: assert property (
        status_load_in |=> status_word_out == $past(status_data_in))
        else $error("status word not loaded");
    AST_PC_WORD: assert property (
        s_pc(4'h9) |-> mem_req_out && !mem_we_out && mem_size_out == 2'b01
        && mem_addr_out == $past(instr_pc_in)
        + {23'h0, $past(instr_in[7:0]), 1'b0})
        else $error("pc word address");
    AST_PC_LONG: assert property (
        s_pc(4'hd) |-> mem_req_out && !mem_we_out && mem_size_out == 2'b10
        && mem_addr_out == $past(instr_pc_in)
        + {22'h0, $past(instr_in[7:0]), 2'b00})
        else $error("pc long address");
endmodule : xfer_monitor

// ### tb/mem_model.sv
// shared memory port model with wait states
// assumes fetch owns the path while fetch_in is high
`timescale 1ns/100ps
module mem_model (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic [1:0]  size_in,
    input  wire logic        fetch_in,
    input  wire logic [1:0]  wait_in,
    output logic             ready_out,
    output logic [31:0]      rdata_out,
    output logic [31:0]      wr_addr_out,
    output logic [31:0]      wr_data_out,
    output logic [1:0]       wr_size_out,
    output logic [15:0]      wr_count_out
);
    logic [1:0]  wait_ff;
    logic [31:0] last_ff;
    // ========================================
    // data path free only while fetch idle
    assign ready_out = req_in && !fetch_in && wait_ff == wait_in;
    // undriven bus shows inverse of last value
    assign rdata_out = ready_out ? {addr_in[15:0] ^ 16'hc3a5,
        ~addr_in[7:0], addr_in[7:0] ^ 8'h80} : ~last_ff;
    always_ff @(posedge clk_in) begin
        last_ff <= rdata_out;
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !req_in || ready_out) begin
            wait_ff <= 2'h0;
        end else if (!fetch_in && wait_ff != wait_in) begin
            wait_ff <= wait_ff + 2'h1;
        end
    end
    // ========================================
    // write capture
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wr_count_out <= 16'h0000;
        end else if (ready_out && we_in) begin
            wr_addr_out  <= addr_in;
            wr_data_out  <= wdata_in;
            wr_size_out  <= size_in;
            wr_count_out <= wr_count_out + 16'h0001;
        end
    end
endmodule : mem_model

// ### tb/cpu_data_transfer_decode_test.sv
// bench for the data-transfer unit
// assumes mem_model on the memory port
`timescale 1ns/100ps
module cpu_data_transfer_decode_test;
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        instr_valid_in = 1'b0;
    logic        fetch_req_in = 1'b0;
    logic        status_load_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic [31:0] instr_pc_in = 32'h0000_0100;
    logic [31:0] status_data_in = 32'h0000_0000;
    logic [1:0]  wt = 2'h0;
    logic        instr_ready_out, mem_req_out, mem_we_out, mem_ready_in;
    logic        illegal_out;
    logic [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in;
    logic [31:0] status_word_out, wa, wd;
    logic [1:0]  mem_size_out, ws;
    logic [15:0] wn, wbase;
    int          fails = 0;
    int          cmp_count = 0;
    cpu_data_transfer_decode dut (.clk_in, .sys_rst_in, .instr_valid_in,
        .instr_in, .instr_pc_in, .instr_ready_out, .fetch_req_in,
        .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out,
        .mem_size_out, .mem_ready_in, .mem_rdata_in, .status_load_in,
        .status_data_in, .status_word_out, .illegal_out);
    mem_model mem (.clk_in, .sys_rst_in, .req_in(mem_req_out),
        .we_in(mem_we_out), .addr_in(mem_addr_out),
        .wdata_in(mem_wdata_out), .size_in(mem_size_out),
        .fetch_in(fetch_req_in), .wait_in(wt), .ready_out(mem_ready_in),
        .rdata_out(mem_rdata_in), .wr_addr_out(wa), .wr_data_out(wd),
        .wr_size_out(ws), .wr_count_out(wn));
    always #5 clk_in = ~clk_in;
    // ========================================
    // shared tasks
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task cmp32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp32
    task issue(input logic [15:0] op);
        int n;
        wbase = wn;
        instr_valid_in = 1'b1;
        instr_in = op;
        n = 0;
        #1;
        while (instr_ready_out !== 1'b1 && n < 50) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        cmp32({31'h0, instr_ready_out}, 32'h0000_0001);
        @(posedge clk_in);
        #1;
    endtask : issue
    task expect_wr(input logic [31:0] a, input logic [31:0] d,
                   input logic [1:0] s);
        int n;
        instr_valid_in = 1'b0;
        n = 0;
        while (wn === wbase && n < 50) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        cmp32({16'h0, wn}, {16'h0, wbase + 16'h1});
        cmp32(wa, a);
        cmp32(wd & (s == 2'b00 ? 32'h0000_00ff : s == 2'b01 ?
            32'h0000_ffff : 32'hffff_ffff), d);
        cmp32({30'h0, ws}, {30'h0, s});
    endtask : expect_wr
    task wr(input logic [15:0] op, input logic [31:0] a,
            input logic [31:0] d, input logic [1:0] s);
        issue(op);
        expect_wr(a, d, s);
    endtask : wr
    task ld(input logic [15:0] op, input logic [3:0] r,
            input logic [31:0] v);
        issue(op);
        wr({8'h2e, r, 4'h2}, 32'h0000_0040, v, 2'b10);
    endtask : ld
    // ========================================
    // scenarios
    task t_stores;
        issue(16'he044);
        issue(16'he180);
        issue(16'he260);
        issue(16'hee40);
        issue(16'hef10);
        wr(16'h2212, 32'h0000_0060, 32'hffff_ff80, 2'b10);
        wr(16'h8023, 32'h0000_0063, 32'h0000_0044, 2'b00);
        wr(16'h8123, 32'h0000_0066, 32'h0000_0044, 2'b01);
        wr(16'h1215, 32'h0000_0074, 32'hffff_ff80, 2'b10);
        wr(16'h2f16, 32'h0000_000c, 32'hffff_ff80, 2'b10);
        wr(16'h2f04, 32'h0000_000b, 32'h0000_0044, 2'b00);
        wr(16'h0f14, 32'h0000_004f, 32'h0000_0080, 2'b00);
        ld(16'h6813, 4'h8, 32'hffff_ff80);
    endtask : t_stores
    task t_loads;
        wt = 2'h2;
        ld(16'h6320, 4'h3, 32'hffff_ffe0);
        ld(16'h6426, 4'h4, 32'hc3c5_9fe0);
        ld(16'h6322, 4'h2, 32'h0000_0064);
        ld(16'h5523, 4'h5, 32'hc3d5_8ff0);
        ld(16'h8421, 4'h0, 32'hffff_ffe5);
        ld(16'h8521, 4'h0, 32'hffff_99e6);
        ld(16'h6321, 4'h3, 32'hffff_9be4);
        ld(16'h9610, 4'h6, 32'hffff_dfa0);
        ld(16'hd710, 4'h7, 32'hc2e5_bfc0);
        wt = 2'h0;
    endtask : t_loads
    task t_fetch;
        fetch_req_in = 1'b1;
        issue(16'h2e52);
        instr_valid_in = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        cmp32({16'h0, wn}, {16'h0, wbase});
        fetch_req_in = 1'b0;
        expect_wr(32'h0000_0040, 32'hc3d5_8ff0, 2'b10);
    endtask : t_fetch
    task t_status;
        status_load_in = 1'b1;
        status_data_in = 32'h4000_0001;
        @(posedge clk_in);
        #1;
        status_load_in = 1'b0;
        cmp32(status_word_out, 32'h4000_0001);
        issue(16'h3000);
        instr_valid_in = 1'b0;
        @(posedge clk_in);
        #1;
        cmp32({31'h0, illegal_out}, 32'h0000_0001);
        ld(16'he305, 4'h3, 32'h0000_0005);
        cmp32(status_word_out, 32'h4000_0001);
    endtask : t_status
    initial begin
        repeat (16) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        @(posedge clk_in);
        #1;
        cmp32(status_word_out, 32'h0000_0000);
        t_stores();
        t_loads();
        t_fetch();
        t_status();
        conclude();
    end
    initial begin
        #100000;
        fails++;
        conclude();
    end
endmodule : cpu_data_transfer_decode_test
bind cpu_data_transfer_decode xfer_monitor mon (.clk_in, .sys_rst_in,
    .instr_valid_in, .instr_in, .instr_pc_in, .instr_ready_out,
    .fetch_req_in, .mem_req_out, .mem_we_out, .mem_addr_out,
    .mem_size_out, .mem_ready_in, .status_load_in, .status_data_in,
    .status_word_out);
